// ---- sevsel_pkg.sv ----
//----------------------------------------------------------------------
// Purpose : Constants for the stall and event selector of the core's
//           performance counter.
// Assumes : Event number and unit mask are eight bits each.
// Notes   : Behaviour list follows.
//----------------------------------------------------------------------
// Behaviour
// RL1 - Event DCH mask 04H counts every cycle with loads at their limit, until a load retires.
// RL2 - The same selection counts every cycle with stores at their limit, until a store commits its data.
// RL3 - The same selection counts every cycle in which an instruction waits for all older stores to commit.
// RL4 - Event DCH mask 08H counts every cycle stalled by a floating-point control word write.
// RL5 - Mask 10H counts cycles from a detected misprediction until that branch and all older micro-ops retire.
// RL6 - Mask 1FH counts once per cycle in which any of the five stall conditions is active.
// RL7 - Event DCH mask 01H counts every cycle in which the retire buffer is full.
// RL8 - Event DCH mask 02H counts every cycle in which the issue queue is full.
// RL9 - Event E0H mask 00H counts once per decoded branch instruction.
// RL10 - Event E4H counts once per byte sequence wrongly taken for a taken branch.
// RL11 - Every false taken branch also raises a front-end resteer, counted under both selections.
// RL12 - Event E6H counts once per front-end resteer.
// RL13 - Event F0H counts once per upward prefetch sent to the second-level cache.
// RL14 - Event F8H counts once per downward prefetch sent to the second-level cache.
// RL15 - A prefetch once sent is never cancelled, so it is counted as soon as it is sent.
// RL16 - The counter advances by at most one per cycle and only while event and mask match.
// RL17 - An unlisted event and mask pair leaves the counter unchanged.
package sevsel_pkg;

  //--------------------------------------------------------------------
  // Selection codes
  //--------------------------------------------------------------------
  localparam logic [7:0] SEVSEL_EVT_STALL   = 8'hDC;
  localparam logic [7:0] SEVSEL_EVT_BR_DEC  = 8'hE0;
  localparam logic [7:0] SEVSEL_EVT_FALSE   = 8'hE4;
  localparam logic [7:0] SEVSEL_EVT_RESTEER = 8'hE6;
  localparam logic [7:0] SEVSEL_EVT_PF_UP   = 8'hF0;
  localparam logic [7:0] SEVSEL_EVT_PF_DN   = 8'hF8;

  localparam logic [7:0] SEVSEL_UM_NONE     = 8'h00;
  localparam logic [7:0] SEVSEL_UM_RETIRE   = 8'h01;
  localparam logic [7:0] SEVSEL_UM_ISSUE    = 8'h02;
  localparam logic [7:0] SEVSEL_UM_LDST     = 8'h04;
  localparam logic [7:0] SEVSEL_UM_FPCW     = 8'h08;
  localparam logic [7:0] SEVSEL_UM_MISS     = 8'h10;
  localparam logic [7:0] SEVSEL_UM_ANY      = 8'h1F;

  //--------------------------------------------------------------------
  // Counter shape and reset values
  //--------------------------------------------------------------------
  localparam int          SEVSEL_CNT_W      = 40;
  localparam logic [39:0] SEVSEL_CNT_RST    = 40'h00_0000_0000;
  localparam logic [39:0] SEVSEL_CNT_ONE    = 40'h00_0000_0001;
  localparam int          SEVSEL_NUM_TRK    = 3;
  localparam int          SEVSEL_TRK_LOAD   = 0;
  localparam int          SEVSEL_TRK_STORE  = 1;
  localparam int          SEVSEL_TRK_MISS   = 2;

endpackage

// ---- sevsel_tracker.sv ----
//----------------------------------------------------------------------
// Purpose : Holds one stall condition from its start pulse to its end pulse.
// Assumes : Start and end come from logic on the same clock.
// Notes   : A start in the cycle of an end keeps the condition set.
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module sevsel_tracker
  import sevsel_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Condition edges
  input  wire logic start,
  input  wire logic finish,
  // Condition level
  output logic      active
);

  logic active_r;
  logic active_nxt;

  // A fresh start wins over an end so that no stall is lost.
  always_comb begin
    active_nxt = active_r;
    if (finish) begin
      active_nxt = 1'b0;
    end
    if (start) begin
      active_nxt = 1'b1;
    end
  end

  // Register the held condition.
  always_ff @(posedge clock) begin
    if (rst) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign active = active_r;

  a_start_sets_active: assert property (@(posedge clock) disable iff (rst) // RL1
    start |=> active_r)
    else $error("Tracker did not set after a start.");

  a_end_clears_active: assert property (@(posedge clock) disable iff (rst) // RL2
    (finish && !start) |=> !active_r)
    else $error("Tracker did not clear after an end.");

endmodule
`default_nettype wire

// ---- sevsel_top.sv ----
//----------------------------------------------------------------------
// Purpose : Picks one pipeline condition by event number and unit mask
//           and accumulates it in a free counter.
// Assumes : All event inputs come from core logic on the same clock.
//           Occurrence inputs pulse at most once per cycle.
// Notes   : The counter value is registered; a hit shows one edge later.
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module sevsel_top
  import sevsel_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // Selection and control
  input  wire logic [7:0]              event_sel,
  input  wire logic [7:0]              unit_mask,
  input  wire logic                    count_enable,
  input  wire logic                    count_clear,
  // Stall sources, levels
  input  wire logic                    retire_buffer_full_stall,
  input  wire logic                    issue_queue_full_stall,
  input  wire logic                    store_drain_wait,
  input  wire logic                    fp_control_word_stall,
  // Stall sources, start and end pulses
  input  wire logic                    load_limit_reached,
  input  wire logic                    load_retired,
  input  wire logic                    store_limit_reached,
  input  wire logic                    store_committed,
  input  wire logic                    mispredict_detected,
  input  wire logic                    mispredict_retired,
  // Occurrence sources, pulses
  input  wire logic                    branches_decoded,
  input  wire logic                    false_taken_branch,
  input  wire logic                    frontend_resteer,
  input  wire logic                    upward_prefetch_request,
  input  wire logic                    downward_prefetch_request,
  // Results
  output logic [SEVSEL_CNT_W-1:0]      count_value,
  output logic                         event_hit,
  output logic                         load_store_limit_stall,
  output logic                         mispredict_recovery_stall
);

  //--------------------------------------------------------------------
  // Held stall conditions
  //--------------------------------------------------------------------
  logic [SEVSEL_NUM_TRK-1:0] trk_start;
  logic [SEVSEL_NUM_TRK-1:0] trk_end;
  logic [SEVSEL_NUM_TRK-1:0] trk_active;

  // Start and end pulses for each held condition.
  always_comb begin
    // RL1 load limit edges
    trk_start[SEVSEL_TRK_LOAD]  = load_limit_reached;
    trk_end[SEVSEL_TRK_LOAD]    = load_retired;
    // RL2 store limit edges
    trk_start[SEVSEL_TRK_STORE] = store_limit_reached;
    trk_end[SEVSEL_TRK_STORE]   = store_committed;
    // RL5 mispredict recovery edges
    trk_start[SEVSEL_TRK_MISS]  = mispredict_detected;
    trk_end[SEVSEL_TRK_MISS]    = mispredict_retired;
  end

  // One tracker per held condition.
  genvar gi;
  generate
    for (gi = 0; gi < SEVSEL_NUM_TRK; gi++) begin : g_trk
      sevsel_tracker u_trk (
        .clock  (clock),
        .rst    (rst),
        .start  (trk_start[gi]),
        .finish (trk_end[gi]),
        .active (trk_active[gi])
      );
    end
  endgenerate

  //--------------------------------------------------------------------
  // Stall combination
  //--------------------------------------------------------------------
  logic ldst_stall;
  logic miss_stall;
  logic any_stall;
  logic resteer_any;

  // The load/store class merges both limits and the store drain wait.
  always_comb begin
    // RL3 store drain wait
    ldst_stall  = trk_active[SEVSEL_TRK_LOAD] | trk_active[SEVSEL_TRK_STORE] | store_drain_wait;
    miss_stall  = trk_active[SEVSEL_TRK_MISS];
    // RL6 any stall class
    any_stall   = retire_buffer_full_stall | issue_queue_full_stall | ldst_stall
                | fp_control_word_stall | miss_stall;
    // RL11 false branch resteers
    resteer_any = frontend_resteer | false_taken_branch;
  end

  //--------------------------------------------------------------------
  // Selection decode
  //--------------------------------------------------------------------
  logic hit;

  // Unlisted pairs fall to the default and give no hit.
  always_comb begin
    // RL17 unlisted pairs hold
    hit = 1'b0;
    if (event_sel == SEVSEL_EVT_STALL) begin
      case (unit_mask)
        // RL7 retire buffer full
        SEVSEL_UM_RETIRE: begin
          hit = retire_buffer_full_stall;
        end
        // RL8 issue queue full
        SEVSEL_UM_ISSUE: begin
          hit = issue_queue_full_stall;
        end
        // RL1 load store class
        SEVSEL_UM_LDST: begin
          hit = ldst_stall;
        end
        // RL4 control word stall
        SEVSEL_UM_FPCW: begin
          hit = fp_control_word_stall;
        end
        // RL5 mispredict recovery cycles
        SEVSEL_UM_MISS: begin
          hit = miss_stall;
        end
        // RL6 any stall
        SEVSEL_UM_ANY: begin
          hit = any_stall;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end else if (unit_mask == SEVSEL_UM_NONE) begin
      case (event_sel)
        // RL9 decoded branches
        SEVSEL_EVT_BR_DEC: begin
          hit = branches_decoded;
        end
        // RL10 false taken branches
        SEVSEL_EVT_FALSE: begin
          hit = false_taken_branch;
        end
        // RL12 front-end resteers
        SEVSEL_EVT_RESTEER: begin
          hit = resteer_any;
        end
        // RL15 sent prefetch counts
        // RL13 upward prefetches
        SEVSEL_EVT_PF_UP: begin
          hit = upward_prefetch_request;
        end
        // RL14 downward prefetches
        SEVSEL_EVT_PF_DN: begin
          hit = downward_prefetch_request;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Counter
  //--------------------------------------------------------------------
  logic [SEVSEL_CNT_W-1:0] count_r;
  logic [SEVSEL_CNT_W-1:0] count_nxt;
  logic                    hit_r;
  logic                    hit_nxt;

  // Clear beats a hit; the counter wraps silently at its width.
  always_comb begin
    count_nxt = count_r;
    hit_nxt   = hit & count_enable & ~count_clear;
    if (count_clear) begin
      count_nxt = SEVSEL_CNT_RST;
    end else if (hit_nxt) begin
      // RL16 one step per cycle
      count_nxt = count_r + SEVSEL_CNT_ONE;
    end
  end

  // Register the count and the hit flag.
  always_ff @(posedge clock) begin
    if (rst) begin
      count_r <= SEVSEL_CNT_RST;
      hit_r   <= 1'b0;
    end else begin
      count_r <= count_nxt;
      hit_r   <= hit_nxt;
    end
  end

  assign count_value               = count_r;
  assign event_hit                 = hit_r;
  assign load_store_limit_stall    = ldst_stall;
  assign mispredict_recovery_stall = miss_stall;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  a_load_stall_holds: assert property (@(posedge clock) disable iff (rst) // RL1
    (load_limit_reached && !rst) ##1 !load_retired |=> load_store_limit_stall)
    else $error("Load limit stall dropped before a load retired.");

  a_store_stall_holds: assert property (@(posedge clock) disable iff (rst) // RL2
    (store_limit_reached ##1 (!store_committed && !load_retired)) |=> load_store_limit_stall)
    else $error("Store limit stall dropped before a store committed.");

  a_drain_wait_counts: assert property (@(posedge clock) disable iff (rst) // RL3
    (event_sel == SEVSEL_EVT_STALL && unit_mask == SEVSEL_UM_LDST && store_drain_wait
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Store drain wait cycle not counted.");

  a_fpcw_counts: assert property (@(posedge clock) disable iff (rst) // RL4
    (event_sel == SEVSEL_EVT_STALL && unit_mask == SEVSEL_UM_FPCW && count_enable
     && !count_clear) |=> count_r == $past(count_r) + {39'd0, $past(fp_control_word_stall)})
    else $error("Control word stall count wrong.");

  a_miss_window: assert property (@(posedge clock) disable iff (rst) // RL5
    mispredict_detected ##1 !mispredict_retired[*2] |-> mispredict_recovery_stall)
    else $error("Mispredict recovery ended before retirement.");

  a_any_stall_once: assert property (@(posedge clock) disable iff (rst) // RL6
    (event_sel == SEVSEL_EVT_STALL && unit_mask == SEVSEL_UM_ANY && count_enable && !count_clear
     && retire_buffer_full_stall && fp_control_word_stall) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Any-stall did not count exactly once.");

  a_resteer_both: assert property (@(posedge clock) disable iff (rst) // RL11
    (event_sel == SEVSEL_EVT_RESTEER && unit_mask == SEVSEL_UM_NONE && false_taken_branch
     && count_enable && !count_clear) |=> event_hit)
    else $error("False branch not counted as resteer.");

  a_prefetch_counts: assert property (@(posedge clock) disable iff (rst) // RL15
    (event_sel == SEVSEL_EVT_PF_UP && unit_mask == SEVSEL_UM_NONE && upward_prefetch_request
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Sent prefetch not counted.");

  a_step_at_most_one: assert property (@(posedge clock) disable iff (rst) // RL16
    !$past(count_clear) |-> (count_r == $past(count_r) || count_r == $past(count_r) + SEVSEL_CNT_ONE))
    else $error("Counter moved by more than one.");

  a_unlisted_holds: assert property (@(posedge clock) disable iff (rst) // RL17
    (event_sel == 8'hD5 && !count_clear) |=> $stable(count_r) && !event_hit)
    else $error("Unlisted selection changed the counter.");

  a_clear_zeroes: assert property (@(posedge clock) disable iff (rst) // RL16
    count_clear
    |=> (count_r == SEVSEL_CNT_RST) && !event_hit)
    else $error("Clear did not zero the counter.");

  a_disabled_holds: assert property (@(posedge clock) disable iff (rst) // RL16
    (!count_enable && !count_clear)
    |=> $stable(count_r) && !event_hit)
    else $error("Disabled counter moved.");

  a_hit_marks_step: assert property (@(posedge clock) disable iff (rst) // RL16
    event_hit
    |-> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Hit flag without a counter step.");

  a_retire_full_counts: assert property (@(posedge clock) disable iff (rst) // RL7
    (event_sel == SEVSEL_EVT_STALL && unit_mask == SEVSEL_UM_RETIRE && retire_buffer_full_stall
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Retire buffer full cycle not counted.");

  a_issue_full_counts: assert property (@(posedge clock) disable iff (rst) // RL8
    (event_sel == SEVSEL_EVT_STALL && unit_mask == SEVSEL_UM_ISSUE && issue_queue_full_stall
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Issue queue full cycle not counted.");

  a_miss_counts: assert property (@(posedge clock) disable iff (rst) // RL5
    (event_sel == SEVSEL_EVT_STALL && unit_mask == SEVSEL_UM_MISS && mispredict_recovery_stall
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Mispredict recovery cycle not counted.");

  a_branch_dec_counts: assert property (@(posedge clock) disable iff (rst) // RL9
    (event_sel == SEVSEL_EVT_BR_DEC && unit_mask == SEVSEL_UM_NONE && branches_decoded
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Decoded branch not counted.");

  a_false_br_counts: assert property (@(posedge clock) disable iff (rst) // RL10
    (event_sel == SEVSEL_EVT_FALSE && unit_mask == SEVSEL_UM_NONE && false_taken_branch
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("False taken branch not counted.");

  a_resteer_counts: assert property (@(posedge clock) disable iff (rst) // RL12
    (event_sel == SEVSEL_EVT_RESTEER && unit_mask == SEVSEL_UM_NONE && frontend_resteer
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Front-end resteer not counted.");

  a_down_pf_counts: assert property (@(posedge clock) disable iff (rst) // RL14
    (event_sel == SEVSEL_EVT_PF_DN && unit_mask == SEVSEL_UM_NONE && downward_prefetch_request
     && count_enable && !count_clear) |=> count_r == $past(count_r) + SEVSEL_CNT_ONE)
    else $error("Downward prefetch not counted.");

endmodule
`default_nettype wire

// ---- sevsel_source_model.sv ----
// Purpose : Core-side source model that feeds the stall and event selector.
// Assumes : Sources change 1 ns after the rising clock edge.
// Notes   : Bit order of src matches the source ports of the selector.
`timescale 1ns/100ps
`default_nettype none
module sevsel_source_model (
  // Clock
  input  wire logic        clock,
  // Source lines toward the selector
  output var  logic [14:0] src
);
  //--------------------------------------------------------------------
  // Source driving
  //--------------------------------------------------------------------
  // Sources sit low when idle, so a stale level never counts by itself.
  initial begin
    src = 15'h0000;
  end

  // Raises the given sources for n edges, then drops them all together.
  // prefetch never withdrawn
  task automatic drive(input logic [14:0] v, input int n);
    @(posedge clock);
    #1 src = v;
    repeat (n) @(posedge clock);
    #1 src = 15'h0000;
  endtask
endmodule
`default_nettype wire

// ---- stall_event_selector_bench.sv ----
// Purpose : Self-checking bench for the stall and event selector.
// Assumes : Count deltas are measured two edges after the sources drop.
// Notes   : Each scenario except the inline clear and reset checks is a task that judges its own results.
`timescale 1ns/100ps
`default_nettype none
module stall_event_selector_bench;
  import sevsel_pkg::*;
  logic                    clock, rst, count_enable, count_clear, event_hit;
  logic                    load_store_limit_stall, mispredict_recovery_stall;
  logic [7:0]              event_sel, unit_mask;
  logic [14:0]             src;
  logic [SEVSEL_CNT_W-1:0] count_value, base;
  logic [7:0]              lvl_mask [4] = '{SEVSEL_UM_RETIRE, SEVSEL_UM_ISSUE, SEVSEL_UM_LDST, SEVSEL_UM_FPCW};
  logic [7:0]              occ_evt [5] = '{SEVSEL_EVT_BR_DEC, SEVSEL_EVT_FALSE, SEVSEL_EVT_RESTEER,
                                           SEVSEL_EVT_PF_UP, SEVSEL_EVT_PF_DN};
  int                      miscompares, checks_done;

  sevsel_source_model src_m (.clock(clock), .src(src));

  sevsel_top dut (
    .clock(clock), .rst(rst), .event_sel(event_sel), .unit_mask(unit_mask),
    .count_enable(count_enable), .count_clear(count_clear),
    .retire_buffer_full_stall(src[0]), .issue_queue_full_stall(src[1]),
    .store_drain_wait(src[2]), .fp_control_word_stall(src[3]),
    .load_limit_reached(src[4]), .load_retired(src[5]),
    .store_limit_reached(src[6]), .store_committed(src[7]),
    .mispredict_detected(src[8]), .mispredict_retired(src[9]),
    .branches_decoded(src[10]), .false_taken_branch(src[11]), .frontend_resteer(src[12]),
    .upward_prefetch_request(src[13]), .downward_prefetch_request(src[14]),
    .count_value(count_value), .event_hit(event_hit),
    .load_store_limit_stall(load_store_limit_stall),
    .mispredict_recovery_stall(mispredict_recovery_stall));

  //--------------------------------------------------------------------
  // Shared tasks
  //--------------------------------------------------------------------
  // Counts every comparison and reports a difference at once.
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  // Holds sources v for n edges under one selection and expects exp counts.
  task automatic run(input logic [7:0] sel, input logic [7:0] msk, input logic [14:0] v,
                     input int n, input int exp);
    event_sel = sel;
    unit_mask = msk;
    @(posedge clock);
    #1 base = count_value;
    src_m.drive(v, n);
    check("event_hit", {39'h0, event_hit}, (exp > 0) ? 40'h1 : 40'h0);
    repeat (2) @(posedge clock);
    #1 check("count delta", count_value - base, 40'(exp));
  endtask

  // Opens a held stall with start pulse s, closes it 2 + g cycles later with e.
  task automatic track(input int s, input int e, input logic [7:0] msk, input int g);
    event_sel = SEVSEL_EVT_STALL;
    unit_mask = msk;
    @(posedge clock);
    #1 base = count_value;
    src_m.drive(15'h0001 << s, 1);
    check("stall flag set", {39'h0, (s == 8) ? mispredict_recovery_stall : load_store_limit_stall}, 40'h1);
    repeat (g) @(posedge clock);
    src_m.drive(15'h0001 << e, 1);
    check("stall flag end", {39'h0, (s == 8) ? mispredict_recovery_stall : load_store_limit_stall}, 40'h0);
    repeat (2) @(posedge clock);
    #1 check("held delta", count_value - base, 40'(2 + g));
  endtask

  //--------------------------------------------------------------------
  // Clock, watchdog and main sequence
  //--------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // A hang is cut short well past the longest legal run.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    event_sel = 8'h00;
    unit_mask = 8'h00;
    count_enable = 1'b1;
    count_clear = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    #1 check("reset count", count_value, 40'h00_0000_0000);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      run(SEVSEL_EVT_STALL, lvl_mask[i], 15'h0001 << i, 4, 4);
      run(SEVSEL_EVT_STALL, SEVSEL_UM_ANY, 15'h0001 << i, 4, 4);
      run(SEVSEL_EVT_STALL, lvl_mask[(i + 1) % 4], 15'h0001 << i, 4, 0);
    end
    for (int i = 0; i < 5; i++) begin
      run(occ_evt[i], SEVSEL_UM_NONE, 15'h0001 << (10 + i), 3, 3);
      run(occ_evt[i], SEVSEL_UM_RETIRE, 15'h0001 << (10 + i), 3, 0);
    end
    run(SEVSEL_EVT_RESTEER, SEVSEL_UM_NONE, 15'h0800, 2, 2);
    run(SEVSEL_EVT_RESTEER, SEVSEL_UM_NONE, 15'h1800, 2, 2);
    run(SEVSEL_EVT_STALL, SEVSEL_UM_ANY, 15'h7c0f, 4, 4);
    run(SEVSEL_EVT_STALL, 8'h03, 15'h7c0f, 3, 0);
    run(SEVSEL_EVT_STALL, 8'h20, 15'h7c0f, 3, 0);
    run(8'h55, SEVSEL_UM_NONE, 15'h7c0f, 3, 0);
    run(8'hD5, SEVSEL_UM_NONE, 15'h7c0f, 3, 0);
    track(4, 5, SEVSEL_UM_LDST, 3);
    track(6, 7, SEVSEL_UM_LDST, 0);
    track(8, 9, SEVSEL_UM_MISS, 2);
    track(6, 7, SEVSEL_UM_ANY, 1);
    count_enable = 1'b0;
    run(SEVSEL_EVT_STALL, SEVSEL_UM_FPCW, 15'h0008, 4, 0);
    count_enable = 1'b1;
    // Clear wins over a same-cycle hit, so the counter must land on zero.
    count_clear = 1'b1;
    src_m.drive(15'h0008, 3);
    check("cleared count", count_value, 40'h00_0000_0000);
    check("hit under clear", {39'h0, event_hit}, 40'h0);
    count_clear = 1'b0;
    // A reset in mid-stall must drop the held load condition.
    event_sel = SEVSEL_EVT_STALL;
    unit_mask = SEVSEL_UM_LDST;
    src_m.drive(15'h0010, 1);
    rst = 1'b1;
    @(posedge clock);
    #1 check("flag after reset", {39'h0, load_store_limit_stall}, 40'h0);
    rst = 1'b0;
    check("count after reset", count_value, 40'h00_0000_0000);
    run(SEVSEL_EVT_STALL, SEVSEL_UM_FPCW, 15'h0008, 2, 2);
    report_and_stop;
  end
endmodule
`default_nettype wire
